/* File: design/shirc_top.sv */
`timescale 1ns/1ps
`include "shirc_consts.svh"
// Notes on behaviour
// - bits 25..20 exclude groups; bit 26 sync enable
// - sync pin output select, reset low
// - qualify sync by clock output when set
// - sync input polarity, reset active low
// - auto sync on divider writes when set
// - crystal oscillator enable, reset off
// - lock pin select 3, type push-pull
// - hold sync until loop2 locks
// - hold sync until loop1 locks
// - tuning voltage tracking, reset enabled
// - holdover mode field, reset enables holdover
// - holdover pin type 3, select 7
// - status1 pin select, reset low
// - status0 type pulldown, select low
// - mask loop1 unlock edge from holdover
// - reference select mode, reset manual
// - invert both status pin inputs
// - bits 7,6,5 mark refs 2,1,0 usable
// - loss timeout field, reset 1200 ns
// - loss detect enable, reset on
module shirc_top
  import shirc_pkg::*;
(
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // ahb-lite slave
  input  wire logic        i_hsel,
  input  wire logic [7:0]  i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic      [31:0] o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  // device status inputs
  input  wire logic        i_loop1_digital_lock_detect,
  input  wire logic        i_loop2_digital_lock_detect,
  input  wire logic [2:0]  i_ref_activity,
  // sync control
  output logic             o_sync_enable,
  output logic [5:0]       o_group_sync_exclude,
  output logic [1:0]       o_sync_pin_output_select,
  output logic             o_sync_qualify_enable,
  output logic             o_sync_pin_polarity,
  output logic [2:0]       o_sync_pin_type,
  output logic             o_auto_sync_pulse,
  output logic             o_sync_hold,
  output logic             o_crystal_osc_enable,
  // lock and holdover
  output logic [4:0]       o_lock_pin_select,
  output logic [2:0]       o_lock_pin_type,
  output logic             o_dac_track_enable,
  output logic [1:0]       o_holdover_mode,
  output logic [4:0]       o_holdover_pin_select,
  output logic [2:0]       o_holdover_pin_type,
  output logic             o_holdover_unlock_event,
  // status pins and reference selection
  output logic [2:0]       o_status1_pin_select,
  output logic [2:0]       o_status0_pin_type,
  output logic [2:0]       o_status0_pin_select,
  output logic [2:0]       o_ref_select_mode,
  output logic             o_status_input_invert,
  output logic [2:0]       o_ref_usable,
  // loss of signal
  output logic [1:0]       o_signal_loss_timeout,
  output logic             o_signal_loss_detect_enable,
  output logic [2:0]       o_loss_of_signal
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  localparam int unsigned LOS_CYC0 = `SHIRC_LOS_CYC0;
  localparam int unsigned LOSW     = 9;

  typedef struct packed {
    shirc_phase_t     phase;
    logic [2:0]       idx;
    logic [2:0][LOSW-1:0] los_cnt;
    logic [2:0]       loss_of_signal;
    logic             l1_lock_d;
    logic             unlock_ev;
    logic             auto_sync;
  } shirc_state_t;

  shirc_state_t st_reg;
  shirc_state_t st_next;

  logic [31:0] w0;
  logic [31:0] w1;
  logic [31:0] w2;
  logic [31:0] w3;
  logic [31:0] rf_rdata;
  logic        rf_we;
  logic        swrst;
  logic        ctl_we;
  logic [2:0]  addr_idx;
  logic [31:0] status_word;

  // ----------------------------------------
  // bus address and data phase decode
  // ----------------------------------------
  wire logic take = i_hsel && i_hready && i_htrans[1];

  always_comb begin
    rf_we  = 1'b0;
    ctl_we = 1'b0;
    if (st_reg.phase == SHIRC_DP_WRITE) begin
      rf_we  = (st_reg.idx[2] == 1'b0);
      ctl_we = (st_reg.idx == 3'd4);
    end
  end

  assign swrst = ctl_we && i_hwdata[`SHIRC_SWRST_BIT];

  shirc_regfile u_regfile (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_swrst (swrst),
    .i_we    (rf_we),
    .i_widx  (st_reg.idx[1:0]),
    .i_wdata (i_hwdata),
    .i_ridx  (addr_idx[1:0]),
    .o_rdata (rf_rdata),
    .o_word0 (w0),
    .o_word1 (w1),
    .o_word2 (w2),
    .o_word3 (w3)
  );

  // word index 0..3, control 4, status 5, unmapped 7
  always_comb begin
    unique case (i_haddr)
      `SHIRC_OFF_SYNC_OSC:   addr_idx = 3'd0;
      `SHIRC_OFF_LOCK_HOLD:  addr_idx = 3'd1;
      `SHIRC_OFF_HOLD_INSEL: addr_idx = 3'd2;
      `SHIRC_OFF_INPUT_LOSS: addr_idx = 3'd3;
      `SHIRC_OFF_CONTROL:    addr_idx = 3'd4;
      `SHIRC_OFF_STATUS:     addr_idx = 3'd5;
      default:               addr_idx = 3'd7;
    endcase
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    st_next           = st_reg;
    st_next.auto_sync = 1'b0;
    st_next.unlock_ev = 1'b0;
    st_next.l1_lock_d = i_loop1_digital_lock_detect;
    if (take) begin
      st_next.phase   = i_hwrite ? SHIRC_DP_WRITE : SHIRC_DP_READ;
      st_next.idx     = addr_idx;
    end else begin
      st_next.phase = SHIRC_DP_IDLE;
    end
    // a control write with the divider write bit set starts sync only with auto enabled
    if (ctl_we && i_hwdata[`SHIRC_DIVWR_BIT] && w0[`SHIRC_SYNC_AUTO_BIT]) begin
      st_next.auto_sync = w0[`SHIRC_SYNC_EN_BIT];
    end
    // loop1 lock falling edge triggers holdover when holdover mode bit 1 is set, unless masked
    if (st_reg.l1_lock_d && !i_loop1_digital_lock_detect
        && !w2[`SHIRC_L1_MASK_BIT] && w1[`SHIRC_HOLD_MODE_LSB+1]) begin
      st_next.unlock_ev = 1'b1;
    end
    for (int r = 0; r < 3; r++) begin
      if (!w3[`SHIRC_LOS_EN_BIT] || i_ref_activity[r]) begin
        st_next.los_cnt[r] = '0;
        st_next.loss_of_signal[r]     = 1'b0;
      end else if (st_reg.los_cnt[r] >= LOSW'(LOS_CYC0 << w3[`SHIRC_LOS_TO_LSB+:2])) begin
        st_next.loss_of_signal[r] = 1'b1;
      end else begin
        st_next.los_cnt[r] = st_reg.los_cnt[r] + LOSW'(1);
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_reg <= '{phase: SHIRC_DP_IDLE, idx: 3'd0, los_cnt: '0, loss_of_signal: 3'b0,
                  l1_lock_d: 1'b0, unlock_ev: 1'b0, auto_sync: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------
  // read data and bus answer
  // ----------------------------------------
  assign status_word = {26'h0, st_reg.loss_of_signal, i_loop2_digital_lock_detect,
                        i_loop1_digital_lock_detect, o_sync_hold};

  always_comb begin
    o_hrdata = 32'h0;
    if (st_reg.phase == SHIRC_DP_READ) begin
      if (st_reg.idx[2] == 1'b0) begin
        o_hrdata = rf_rdata;
      end else if (st_reg.idx == 3'd5) begin
        o_hrdata = status_word;
      end
    end
  end

  assign o_hreadyout = 1'b1;
  assign o_hresp     = 1'b0;

  // ----------------------------------------
  // field outputs
  // ----------------------------------------
  assign o_sync_enable            = w0[`SHIRC_SYNC_EN_BIT];
  assign o_group_sync_exclude     = w0[`SHIRC_EXCL_LSB+:6];
  assign o_sync_pin_output_select = w0[`SHIRC_SYNC_OSEL_LSB+:2];
  assign o_sync_qualify_enable    = w0[`SHIRC_SYNC_QUALIFY_ENABLE_BIT];
  assign o_sync_pin_polarity      = w0[`SHIRC_SYNC_POL_BIT];
  assign o_sync_pin_type          = w0[`SHIRC_SYNC_TYPE_LSB+:3];
  assign o_crystal_osc_enable     = w0[`SHIRC_XTAL_BIT];
  assign o_auto_sync_pulse        = st_reg.auto_sync;
  assign o_lock_pin_select        = w1[`SHIRC_PIN_SEL_LSB+:5];
  assign o_lock_pin_type          = w1[`SHIRC_PIN_TYPE_LSB+:3];
  assign o_sync_hold = (w1[`SHIRC_HOLD_L2_BIT] && !i_loop2_digital_lock_detect)
                    || (w1[`SHIRC_HOLD_L1_BIT] && !i_loop1_digital_lock_detect);
  assign o_dac_track_enable       = w1[`SHIRC_TRACK_BIT];
  assign o_holdover_mode          = w1[`SHIRC_HOLD_MODE_LSB+:2];
  assign o_holdover_pin_select    = w2[`SHIRC_PIN_SEL_LSB+:5];
  assign o_holdover_pin_type      = w2[`SHIRC_PIN_TYPE_LSB+:3];
  assign o_holdover_unlock_event  = st_reg.unlock_ev;
  assign o_status1_pin_select     = w2[`SHIRC_ST1_SEL_LSB+:3];
  assign o_status0_pin_type       = w2[`SHIRC_ST0_TYPE_LSB+:3];
  assign o_status0_pin_select     = w2[`SHIRC_ST0_SEL_LSB+:3];
  assign o_ref_select_mode        = w2[`SHIRC_REF_MODE_LSB+:3];
  assign o_status_input_invert    = w2[`SHIRC_ST_INV_BIT];
  assign o_ref_usable             = w2[`SHIRC_REF_USE_LSB+:3];
  assign o_signal_loss_timeout    = w3[`SHIRC_LOS_TO_LSB+:2];
  assign o_signal_loss_detect_enable = w3[`SHIRC_LOS_EN_BIT];
  assign o_loss_of_signal         = st_reg.loss_of_signal;
endmodule

/* File: design/shirc_consts.svh */
`ifndef SHIRC_CONSTS_SVH
`define SHIRC_CONSTS_SVH

// register indices; byte address is four times the index
`define SHIRC_IDX_SYNC_OSC    11
`define SHIRC_IDX_LOCK_HOLD   12
`define SHIRC_IDX_HOLD_INSEL  13
`define SHIRC_IDX_INPUT_LOSS  14

// register byte offsets
`define SHIRC_OFF_SYNC_OSC    (8'(4 * `SHIRC_IDX_SYNC_OSC))
`define SHIRC_OFF_LOCK_HOLD   (8'(4 * `SHIRC_IDX_LOCK_HOLD))
`define SHIRC_OFF_HOLD_INSEL  (8'(4 * `SHIRC_IDX_HOLD_INSEL))
`define SHIRC_OFF_INPUT_LOSS  (8'(4 * `SHIRC_IDX_INPUT_LOSS))
`define SHIRC_OFF_CONTROL     8'h10
`define SHIRC_OFF_STATUS      8'h14

// implemented bit masks
`define SHIRC_MASK_SYNC_OSC   32'h07fff020
`define SHIRC_MASK_LOCK_HOLD  32'hffc001c0
`define SHIRC_MASK_HOLD_INSEL 32'hff77ffe0
`define SHIRC_MASK_INPUT_LOSS 32'hd0000000

// reset values
`define SHIRC_RST_SYNC_OSC    32'h05811000
`define SHIRC_RST_LOCK_HOLD   32'h1b000180
`define SHIRC_RST_HOLD_INSEL  32'h3b0206e0
`define SHIRC_RST_INPUT_LOSS  32'h10000000

// field positions
`define SHIRC_SYNC_EN_BIT     26
`define SHIRC_EXCL_LSB        20
`define SHIRC_SYNC_OSEL_LSB   18
`define SHIRC_SYNC_QUALIFY_ENABLE_BIT   17
`define SHIRC_SYNC_POL_BIT    16
`define SHIRC_SYNC_AUTO_BIT   15
`define SHIRC_SYNC_TYPE_LSB   12
`define SHIRC_XTAL_BIT        5
`define SHIRC_PIN_SEL_LSB     27
`define SHIRC_PIN_TYPE_LSB    24
`define SHIRC_HOLD_L2_BIT     23
`define SHIRC_HOLD_L1_BIT     22
`define SHIRC_TRACK_BIT       8
`define SHIRC_HOLD_MODE_LSB   6
`define SHIRC_ST1_SEL_LSB     20
`define SHIRC_ST0_TYPE_LSB    16
`define SHIRC_L1_MASK_BIT     15
`define SHIRC_ST0_SEL_LSB     12
`define SHIRC_REF_MODE_LSB    9
`define SHIRC_ST_INV_BIT      8
`define SHIRC_REF_USE_LSB     5
`define SHIRC_LOS_TO_LSB      30
`define SHIRC_LOS_EN_BIT      28
`define SHIRC_SWRST_BIT       0
`define SHIRC_DIVWR_BIT       1

// loss timeout at setting 0
`define SHIRC_LOS_TIME0_NS    1200
`define SHIRC_CLK_NS          20
`define SHIRC_LOS_CYC0        (`SHIRC_LOS_TIME0_NS / `SHIRC_CLK_NS)

`endif

/* File: design/shirc_pkg.sv */
package shirc_pkg;
  typedef enum logic [1:0] {
    SHIRC_DP_IDLE,
    SHIRC_DP_WRITE,
    SHIRC_DP_READ
  } shirc_phase_t;
endpackage

/* File: design/shirc_regfile.sv */
`timescale 1ns/1ps
`include "shirc_consts.svh"
// ----------------------------------------
// four configuration words with reset and masks
// ----------------------------------------
module shirc_regfile
  import shirc_pkg::*;
(
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_swrst,
  // write port
  input  wire logic        i_we,
  input  wire logic [1:0]  i_widx,
  input  wire logic [31:0] i_wdata,
  // read port
  input  wire logic [1:0]  i_ridx,
  output logic      [31:0] o_rdata,
  // live words
  output logic      [31:0] o_word0,
  output logic      [31:0] o_word1,
  output logic      [31:0] o_word2,
  output logic      [31:0] o_word3
);
  typedef struct packed {
    logic [3:0][31:0] word;
    logic [31:0]      rdata;
  } shirc_rf_state_t;

  localparam logic [3:0][31:0] RST_VAL = {`SHIRC_RST_INPUT_LOSS, `SHIRC_RST_HOLD_INSEL,
                                          `SHIRC_RST_LOCK_HOLD, `SHIRC_RST_SYNC_OSC};
  localparam logic [3:0][31:0] MASK    = {`SHIRC_MASK_INPUT_LOSS, `SHIRC_MASK_HOLD_INSEL,
                                          `SHIRC_MASK_LOCK_HOLD, `SHIRC_MASK_SYNC_OSC};

  shirc_rf_state_t st_reg;
  shirc_rf_state_t st_next;

  always_comb begin
    st_next = st_reg;
    for (int i = 0; i < 4; i++) begin
      if (i_swrst) begin
        st_next.word[i] = RST_VAL[i];
      end else if (i_we && (i_widx == 2'(i))) begin
        st_next.word[i] = i_wdata & MASK[i];
      end
    end
    st_next.rdata = st_next.word[i_ridx];
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_reg.word  <= RST_VAL;
      st_reg.rdata <= 32'h0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_rdata = st_reg.rdata;
  assign o_word0 = st_reg.word[0];
  assign o_word1 = st_reg.word[1];
  assign o_word2 = st_reg.word[2];
  assign o_word3 = st_reg.word[3];
endmodule

/* File: sim/shirc_chk.sv */
`timescale 1ns/1ps
// ----------------------------------------
// port checker
// ----------------------------------------
module shirc_chk (
  // clock, reset and bus
  input wire logic       i_clk,
  input wire logic       i_rst,
  input wire logic       i_hsel,
  input wire logic [1:0] i_htrans,
  input wire logic       i_hwrite,
  input wire logic       i_hready,
  // status inputs
  input wire logic       i_loop1_digital_lock_detect,
  input wire logic       i_loop2_digital_lock_detect,
  input wire logic [2:0] i_ref_activity,
  // watched outputs
  input wire logic       o_sync_enable,
  input wire logic [5:0] o_group_sync_exclude,
  input wire logic       o_sync_hold,
  input wire logic       o_auto_sync_pulse,
  input wire logic [1:0] o_holdover_mode,
  input wire logic       o_holdover_unlock_event,
  input wire logic [2:0] o_ref_usable,
  input wire logic [1:0] o_signal_loss_timeout,
  input wire logic       o_signal_loss_detect_enable,
  input wire logic [2:0] o_loss_of_signal
);
  logic        wr_q;
  logic [15:0] quiet;
  // write data phase and quiet run on ref 0
  always_ff @(posedge i_clk) begin
    wr_q  <= !i_rst && i_hsel && i_hready && i_htrans[1] && i_hwrite;
    quiet <= (i_rst || i_ref_activity[0] || !o_signal_loss_detect_enable) ? 16'h0
             : quiet + {15'h0, ~&quiet};
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  sequence pulse_once(s);
    s ##1 !s;
  endsequence
  reset_dflt_a: assert property (disable iff (1'b0)
    i_rst |=> o_sync_enable && o_group_sync_exclude == 6'h18 && o_holdover_mode == 2'h2
      && o_ref_usable == 3'h7 && o_signal_loss_detect_enable && o_loss_of_signal == 3'h0)
    else $error("fields not at defaults after reset");
  cfg_hold_a: assert property (!wr_q |=> $stable({o_sync_enable, o_group_sync_exclude,
    o_holdover_mode, o_ref_usable, o_signal_loss_timeout}))
    else $error("field changed without a write");
  hold_release_a: assert property (
    i_loop1_digital_lock_detect && i_loop2_digital_lock_detect |-> !o_sync_hold)
    else $error("sync held with both loops locked");
  auto_pulse_a: assert property (o_auto_sync_pulse |-> o_sync_enable
    && ($past(wr_q) || $past(wr_q, 2) || $past(wr_q, 3)) ##0 pulse_once(o_auto_sync_pulse))
    else $error("auto sync pulse without a write");
  unlock_evt_a: assert property (o_holdover_unlock_event |-> o_holdover_mode[1]
    && !$past(i_loop1_digital_lock_detect) ##0 pulse_once(o_holdover_unlock_event))
    else $error("unlock event without loop1 lock loss");
  los_off_a: assert property (
    !o_signal_loss_detect_enable ##1 !o_signal_loss_detect_enable |-> o_loss_of_signal == 3'h0)
    else $error("loss flagged while detect is off");
  los_clear_a: assert property (
    i_ref_activity[0] ##1 i_ref_activity[0] |=> !o_loss_of_signal[0])
    else $error("loss flagged on an active input");
  los_early_a: assert property ($rose(o_loss_of_signal[0]) |-> quiet >= 16'd58)
    else $error("loss flagged too early");
  los_late_a: assert property (
    quiet == 16'd64 && o_signal_loss_timeout == 2'h0 |-> o_loss_of_signal[0])
    else $error("loss not flagged after timeout");
endmodule
bind shirc_top shirc_chk u_chk (.*);

/* File: sim/shirc_host.sv */
`timescale 1ns/1ps
// ----------------------------------------
// bus host: single word transfers
// ----------------------------------------
module shirc_host (
  // bus
  input  wire logic        i_clk,
  input  wire logic        i_hready,
  input  wire logic [31:0] i_hrdata,
  output logic             o_hsel,
  output logic [7:0]       o_haddr,
  output logic [1:0]       o_htrans,
  output logic             o_hwrite,
  output logic [31:0]      o_hwdata
);
  int stuck = 0;
  initial begin
    o_hsel   = 1'b1;
    o_haddr  = 8'h00;
    o_htrans = 2'h0;
    o_hwrite = 1'b0;
    o_hwdata = 32'h0;
  end
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (i_hready !== 1'b1 && n < 32);
    if (i_hready !== 1'b1) stuck++;
  endtask
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    @(posedge i_clk);
    o_haddr  <= a;
    o_hwrite <= wr;
    o_htrans <= 2'h2;
    wait_rdy();
    o_htrans <= 2'h0;
    o_hwdata <= wd;
    wait_rdy();
    rd = i_hrdata;
    o_hwdata <= ~wd;
  endtask
endmodule

/* File: sim/shirc_top_test.sv */
`timescale 1ns/1ps
// ----------------------------------------
// register bank bench
// ----------------------------------------
module shirc_top_test;
  localparam int QUIET = 1200 / 20;
  logic        i_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic        i_loop1_digital_lock_detect = 1'b1;
  logic        i_loop2_digital_lock_detect = 1'b1;
  logic [2:0]  i_ref_activity = 3'h7;
  logic [2:0]  i_hsize = 3'h2;
  logic        i_hsel, i_hwrite, i_hready, o_hreadyout, o_hresp;
  logic [7:0]  i_haddr;
  logic [1:0]  i_htrans;
  logic [31:0] i_hwdata, o_hrdata, v;
  logic        o_sync_enable, o_sync_qualify_enable, o_sync_pin_polarity, o_auto_sync_pulse;
  logic        o_sync_hold, o_crystal_osc_enable, o_dac_track_enable, o_holdover_unlock_event;
  logic        o_status_input_invert, o_signal_loss_detect_enable;
  logic [1:0]  o_sync_pin_output_select, o_holdover_mode, o_signal_loss_timeout;
  logic [2:0]  o_sync_pin_type, o_lock_pin_type, o_holdover_pin_type, o_status1_pin_select;
  logic [2:0]  o_status0_pin_type, o_status0_pin_select, o_ref_select_mode, o_ref_usable;
  logic [2:0]  o_loss_of_signal;
  logic [4:0]  o_lock_pin_select, o_holdover_pin_select;
  logic [5:0]  o_group_sync_exclude;
  int          errors = 0;
  int          n_compared = 0;
  int          pulses = 0;
  int          events = 0;
  logic [31:0] df [4] = '{32'h05811000, 32'h1b000180, 32'h3b0206e0, 32'h10000000};
  logic [31:0] rm [4] = '{32'h07fff020, 32'hffc001c0, 32'hff77ffe0, 32'hd0000000};
  logic [31:0] vm [4] = '{32'h07ff7020, 32'hff0001c0, 32'hff777fe0, 32'hd0000000};
  assign i_hready = o_hreadyout;
  always #10 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    pulses <= pulses + int'(o_auto_sync_pulse === 1'b1);
    events <= events + int'(o_holdover_unlock_event === 1'b1);
  end
  shirc_top DUT (.*);
  shirc_host u_host (
    .i_clk    (i_clk),
    .i_hready (i_hready),
    .i_hrdata (o_hrdata),
    .o_hsel   (i_hsel),
    .o_haddr  (i_haddr),
    .o_htrans (i_htrans),
    .o_hwrite (i_hwrite),
    .o_hwdata (i_hwdata)
  );
  // output ports placed at their register bit positions
  function automatic logic [31:0] view(input int i);
    case (i)
      0: return {5'h0, o_sync_enable, o_group_sync_exclude, o_sync_pin_output_select,
                 o_sync_qualify_enable, o_sync_pin_polarity, 1'b0, o_sync_pin_type, 6'h0,
                 o_crystal_osc_enable, 5'h0};
      1: return {o_lock_pin_select, o_lock_pin_type, 15'h0, o_dac_track_enable,
                 o_holdover_mode, 6'h0};
      2: return {o_holdover_pin_select, o_holdover_pin_type, 1'b0, o_status1_pin_select, 1'b0,
                 o_status0_pin_type, 1'b0, o_status0_pin_select, o_ref_select_mode,
                 o_status_input_invert, o_ref_usable, 5'h0};
      default: return {o_signal_loss_timeout, 1'b0, o_signal_loss_detect_enable, 28'h0};
    endcase
  endfunction
  task automatic end_of_test();
    errors += u_host.stuck;
    if (errors == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    u_host.xfer(1'b1, a, d, x);
    if (u_host.stuck != 0) end_of_test();
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    u_host.xfer(1'b0, a, 32'h0, x);
    if (u_host.stuck != 0) end_of_test();
    chk(x, e);
    chk(32'(o_hresp), 32'h0);
  endtask
  task automatic drop(input int exp);
    i_loop1_digital_lock_detect <= 1'b0;
    repeat (4) @(posedge i_clk);
    chk(events, exp);
    i_loop1_digital_lock_detect <= 1'b1;
    repeat (2) @(posedge i_clk);
  endtask
  initial begin
    repeat (12) @(posedge i_clk);
    i_rst <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      rd(8'(4 * (11 + i)), df[i]);
      chk(view(i), df[i] & vm[i]);
      for (int k = 0; k < 2; k++) begin
        v = k ? rm[i] : df[i] ^ rm[i];
        wr(8'(4 * (11 + i)), k ? 32'hffffffff : v);
        rd(8'(4 * (11 + i)), v);
        chk(view(i), v & vm[i]);
      end
    end
    wr(8'h10, 32'h1);
    wr(8'h18, 32'hffffffff);
    rd(8'h18, 32'h0);
    for (int i = 0; i < 4; i++) rd(8'(4 * (11 + i)), df[i]);
    wr(8'h10, 32'h2);
    repeat (4) @(posedge i_clk);
    chk(pulses, 0);
    wr(8'h2c, df[0] | 32'h8000);
    wr(8'h10, 32'h2);
    repeat (4) @(posedge i_clk);
    chk(pulses, 1);
    for (int b = 1; b < 4; b++) begin
      wr(8'h30, df[1] | (32'(b) << 22));
      for (int j = 0; j < 4; j++) begin
        {i_loop2_digital_lock_detect, i_loop1_digital_lock_detect} <= 2'(j);
        repeat (2) @(posedge i_clk);
        chk(32'(o_sync_hold), 32'((b[1] && !j[1]) || (b[0] && !j[0])));
      end
    end
    wr(8'h30, df[1]);
    drop(7);
    wr(8'h34, df[2] | 32'h8000);
    drop(7);
    wr(8'h34, df[2]);
    wr(8'h30, df[1] & ~32'h80);
    drop(7);
    i_ref_activity <= 3'h6;
    repeat (QUIET - 5) @(posedge i_clk);
    chk(32'(o_loss_of_signal), 32'h0);
    repeat (10) @(posedge i_clk);
    chk(32'(o_loss_of_signal), 32'h1);
    rd(8'h14, 32'h0000000e);
    wr(8'h38, 32'h0);
    repeat (2) @(posedge i_clk);
    chk(32'(o_loss_of_signal), 32'h0);
    end_of_test();
  end
endmodule
